/* File: rtl/pdr_pkg.sv */
package pdr_pkg;
	// register offsets on the internal register port
	localparam logic [7:0] ADDR_EXT_CAP = 8'h27;
	localparam logic [7:0] ADDR_STD_IN_CAP = 8'h28;
	localparam logic [7:0] ADDR_STD_OUT_CAP = 8'h29;
	localparam logic [7:0] ADDR_EXT_CFG = 8'h2a;
	localparam logic [7:0] ADDR_ACK_HDR = 8'h2e;
	localparam logic [7:0] ADDR_RX_DET = 8'h2f;
	// fixed capability contents
	localparam logic [7:0] EXT_CAP_VALUE = 8'h01;
	localparam logic [7:0] STD_IN_CAP_VALUE = 8'h00;
	localparam logic [7:0] STD_OUT_CAP_VALUE = 8'h00;
	localparam logic [7:0] EXT_CFG_VALUE = 8'h00;
	// field positions
	localparam int EXT_CAP_WATCHDOG_BIT = 0;
	localparam int EXT_CAP_LONG_MSG_BIT = 4;
	localparam int EXT_CFG_BIDIR_BIT = 1;
	localparam int DET_FULL_RESET_BIT = 5;
	localparam int DET_PLUG_RESET_BIT = 6;
	localparam int HDR_WIDTH = 5;
	localparam int DET_WIDTH = 7;
	// largest message content accepted, in bytes
	localparam logic [8:0] MAX_MSG_BYTES = 9'h01e;
	// highest frame type that is an acknowledged message (sop .. debug far plug)
	localparam logic [2:0] LAST_MSG_TYPE = 3'h4;
	// header fields used for the automatic acknowledge
	typedef struct packed {
		logic origin_is_plug;
		logic data_role;
		logic [1:0] spec_revision_field;
		logic port_power_direction;
	} pdr_hdr_t;
	localparam pdr_hdr_t HDR_RESET = 5'h0d;
	localparam logic [DET_WIDTH-1:0] DET_RESET = 7'h00;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} pdr_ack_st_t;
	// whole state of the register bank
	typedef struct packed {
		pdr_hdr_t hdr;
		logic [DET_WIDTH-1:0] det;
		logic one_more;
		logic ack_one_more;
		pdr_ack_st_t st;
		logic [7:0] rdata;
		logic rvalid;
		logic err;
		logic cnt_clr;
	} pdr_state_t;
endpackage : pdr_pkg

/* File: rtl/pdr_regs.sv */
`timescale 1ns/1ps
// How it works
// - capability registers are fixed constants; writes never change them
// - extended capability reads watchdog supported only, bit 0 set
// - long messages reported unsupported; content limited to thirty bytes
// - standard input capability reads all zero
// - standard output capability reads all zero
// - writing bidirectional swap bit flags bus error, ignored, reads zero
// - source swap input bit is read-only and reads zero
// - header fields reset to plug 0, dfp, revision 3.0, source
// - acknowledge header always taken from current header register
// - header bit layout: plug, data role, revision, power role
// - acknowledge each enabled message, never an acknowledge message
// - all enables zero stops acknowledges and drops pending one-more
// - reset signalling, one-more acknowledge, disconnect clear enables and count
// - detect register resets zero; bits 6..3 enable resets and debug types
// - bits 2..0 enable far plug, near plug and port messages
module pdr_regs
	import pdr_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	// register port from the serial target
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	output logic I2C_ERR_SET_OUT,
	// receive events from the protocol layer
	input wire logic RX_MSG_VALID_IN,
	input wire logic [2:0] RX_FRAME_TYPE_IN,
	input wire logic [8:0] RX_LEN_IN,
	input wire logic RX_IS_ACK_IN,
	input wire logic RX_ONE_MORE_IN,
	input wire logic HARD_RESET_SENT_IN,
	input wire logic HARD_RESET_RX_IN,
	input wire logic CABLE_RESET_RX_IN,
	input wire logic DISCONNECT_IN,
	// acknowledge transmit handshake
	output logic ACK_REQ_OUT,
	input wire logic ACK_DONE_IN,
	output pdr_hdr_t ACK_HEADER_OUT,
	// detection state for the receiver
	output logic [DET_WIDTH-1:0] RX_DETECT_OUT,
	output logic RX_COUNT_CLEAR_OUT
);

	pdr_state_t s_r;
	pdr_state_t s_nxt;
	logic clr_all;
	logic type_en;

	// register read decode, fixed values for capability registers
	function automatic logic [7:0] read_value(input logic [7:0] addr, input pdr_state_t st);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			ADDR_EXT_CAP: v = EXT_CAP_VALUE;
			ADDR_STD_IN_CAP: v = STD_IN_CAP_VALUE;
			ADDR_STD_OUT_CAP: v = STD_OUT_CAP_VALUE;
			ADDR_EXT_CFG: v = EXT_CFG_VALUE;
			ADDR_ACK_HDR: v = {3'h0, st.hdr};
			ADDR_RX_DET: v = {1'h0, st.det};
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_value

	// frame type selects its enable bit; resets come on separate strobes
	function automatic logic msg_enabled(input logic [2:0] ftype, input logic [6:0] det);
		logic e;
		e = 1'b0;
		if (ftype <= LAST_MSG_TYPE)
		begin
			e = det[ftype];
		end
		return e;
	endfunction : msg_enabled

	// events that wipe the enables and the readable count
	always_comb
	begin
		clr_all = HARD_RESET_SENT_IN
			| (HARD_RESET_RX_IN & s_r.det[DET_FULL_RESET_BIT])
			| (CABLE_RESET_RX_IN & s_r.det[DET_PLUG_RESET_BIT])
			| DISCONNECT_IN
			| (s_r.st == ST_ACK && ACK_DONE_IN && s_r.ack_one_more);
		// oversize content is not a message this port accepts
		type_en = msg_enabled(RX_FRAME_TYPE_IN, s_r.det)
			&& (RX_LEN_IN <= MAX_MSG_BYTES);
	end

	// next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.err = 1'b0;
		s_nxt.cnt_clr = 1'b0;
		// reads return the value seen at the request edge
		if (REG_RD_IN)
		begin
			s_nxt.rdata = read_value(REG_ADDR_IN, s_r);
			s_nxt.rvalid = 1'b1;
		end
		// writes; capability registers have no storage to change
		if (REG_WR_IN)
		begin
			case (REG_ADDR_IN)
				ADDR_ACK_HDR: s_nxt.hdr = pdr_hdr_t'(REG_WDATA_IN[HDR_WIDTH-1:0]);
				ADDR_RX_DET: s_nxt.det = REG_WDATA_IN[DET_WIDTH-1:0];
				ADDR_EXT_CFG: s_nxt.err = REG_WDATA_IN[EXT_CFG_BIDIR_BIT];
				default: s_nxt.det = s_nxt.det;
			endcase
		end
		if (RX_ONE_MORE_IN)
		begin
			s_nxt.one_more = 1'b1;
		end
		// acknowledge sequencing
		case (s_r.st)
			ST_IDLE:
			begin
				// an acknowledge is never answered with another
				if (RX_MSG_VALID_IN && type_en && !RX_IS_ACK_IN)
				begin
					s_nxt.st = ST_ACK;
					s_nxt.ack_one_more = s_r.one_more;
					// a command that lands with the message waits for the following one
					s_nxt.one_more = RX_ONE_MORE_IN;
				end
			end
			ST_ACK:
			begin
				if (ACK_DONE_IN)
				begin
					s_nxt.st = ST_IDLE;
					s_nxt.ack_one_more = 1'b0;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
		// device clears win over a manager write in the same cycle
		if (clr_all)
		begin
			s_nxt.det = DET_RESET;
			s_nxt.cnt_clr = 1'b1;
			s_nxt.one_more = 1'b0;
			if (s_r.st == ST_ACK && !ACK_DONE_IN && !s_r.ack_one_more)
			begin
				// the link is being reset, an acknowledge in flight is pointless
				s_nxt.st = ST_IDLE;
			end
		end
		// with nothing enabled no acknowledge starts and one-more is dropped
		if (s_nxt.det == DET_RESET)
		begin
			s_nxt.one_more = 1'b0;
		end
		if (s_r.det == DET_RESET && s_r.st == ST_IDLE)
		begin
			s_nxt.st = ST_IDLE;
			s_nxt.ack_one_more = 1'b0;
		end
	end

	// state register
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			s_r.hdr <= HDR_RESET;
			s_r.det <= DET_RESET;
			s_r.one_more <= 1'b0;
			s_r.ack_one_more <= 1'b0;
			s_r.st <= ST_IDLE;
			s_r.rdata <= 8'h00;
			s_r.rvalid <= 1'b0;
			s_r.err <= 1'b0;
			s_r.cnt_clr <= 1'b0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// outputs; header is live so a rewrite applies to the next acknowledge
	assign REG_RDATA_OUT = s_r.rdata;
	assign REG_RVALID_OUT = s_r.rvalid;
	assign I2C_ERR_SET_OUT = s_r.err;
	assign ACK_REQ_OUT = (s_r.st == ST_ACK);
	assign ACK_HEADER_OUT = s_r.hdr;
	assign RX_DETECT_OUT = s_r.det;
	assign RX_COUNT_CLEAR_OUT = s_r.cnt_clr;

	// checks on the register map
	a_ext_cap_read: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_EXT_CAP |=> REG_RVALID_OUT && REG_RDATA_OUT == 8'h01)
		else $error("extended capability read wrong");
	a_std_in_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_STD_IN_CAP |=> REG_RDATA_OUT == 8'h00)
		else $error("standard input capability not zero");
	a_std_out_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_STD_OUT_CAP |=> REG_RDATA_OUT == 8'h00)
		else $error("standard output capability not zero");
	a_cap_ro_write: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_WR_IN && REG_ADDR_IN == ADDR_EXT_CAP && !REG_RD_IN
		##1 REG_RD_IN && REG_ADDR_IN == ADDR_EXT_CAP |=> REG_RDATA_OUT == 8'h01)
		else $error("capability changed by write");
	a_bidir_err_flag: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_WR_IN && REG_ADDR_IN == ADDR_EXT_CFG |=>
		I2C_ERR_SET_OUT == $past(REG_WDATA_IN[1]) ##1 !I2C_ERR_SET_OUT || $past(REG_WR_IN))
		else $error("bus error flag wrong after config write");
	a_ext_cfg_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_EXT_CFG |=> REG_RDATA_OUT == 8'h00)
		else $error("extended config reads nonzero");
	a_hdr_write: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_WR_IN && REG_ADDR_IN == ADDR_ACK_HDR |=> ACK_HEADER_OUT == $past(REG_WDATA_IN[4:0]))
		else $error("header not taken from write");
	a_det_write: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_WR_IN && REG_ADDR_IN == ADDR_RX_DET && !clr_all
		|=> RX_DETECT_OUT == $past(REG_WDATA_IN[6:0]))
		else $error("detect enables not written");
	a_ack_enabled: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!ACK_REQ_OUT && RX_MSG_VALID_IN && type_en && !RX_IS_ACK_IN && !clr_all
		|=> ACK_REQ_OUT)
		else $error("enabled message not acknowledged");
	a_no_ack_idle: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!ACK_REQ_OUT && (RX_DETECT_OUT == 7'h00 || RX_IS_ACK_IN) |=> !ACK_REQ_OUT)
		else $error("acknowledge started while not allowed");
	a_reset_clears: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		HARD_RESET_SENT_IN || DISCONNECT_IN |=> RX_DETECT_OUT == 7'h00 && RX_COUNT_CLEAR_OUT)
		else $error("enables not cleared on reset signalling");
	a_one_more_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		ACK_REQ_OUT && ACK_DONE_IN && s_r.ack_one_more
		|=> RX_DETECT_OUT == 7'h00 ##1 !RX_COUNT_CLEAR_OUT || $past(clr_all))
		else $error("one-more acknowledge did not clear enables");
	a_hdr_read_mask: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && (REG_ADDR_IN == ADDR_ACK_HDR || REG_ADDR_IN == ADDR_RX_DET)
		|=> REG_RDATA_OUT[7] == 1'b0)
		else $error("unused bit reads nonzero");

	// checks on the read answer and the fixed map
	a_read_answer: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		1'b1 |=> REG_RVALID_OUT == $past(REG_RD_IN))
		else $error("read answer not one cycle after request");
	a_unmapped_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN != ADDR_EXT_CAP && REG_ADDR_IN != ADDR_STD_IN_CAP
		&& REG_ADDR_IN != ADDR_STD_OUT_CAP && REG_ADDR_IN != ADDR_EXT_CFG
		&& REG_ADDR_IN != ADDR_ACK_HDR && REG_ADDR_IN != ADDR_RX_DET
		|=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped offset reads nonzero");
	a_cfg_no_store: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_WR_IN && REG_ADDR_IN == ADDR_EXT_CFG
		##1 REG_RD_IN && REG_ADDR_IN == ADDR_EXT_CFG |=> REG_RDATA_OUT == 8'h00)
		else $error("extended config kept a written value");
	a_err_cfg_only: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		I2C_ERR_SET_OUT |-> $past(REG_WR_IN) && $past(REG_ADDR_IN) == ADDR_EXT_CFG
		&& $past(REG_WDATA_IN[EXT_CFG_BIDIR_BIT]))
		else $error("bus error flag without a swap bit write");

	// header register is live and only the manager changes it
	a_hdr_stable: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!(REG_WR_IN && REG_ADDR_IN == ADDR_ACK_HDR) |=> $stable(ACK_HEADER_OUT))
		else $error("header changed without a write");
	a_hdr_read_back: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_ACK_HDR
		|=> REG_RDATA_OUT == {3'h0, $past(ACK_HEADER_OUT)})
		else $error("header read differs from header in use");
	a_det_read_back: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		REG_RD_IN && REG_ADDR_IN == ADDR_RX_DET
		|=> REG_RDATA_OUT == {1'h0, $past(RX_DETECT_OUT)})
		else $error("detect read differs from enables in use");

	// acknowledge handshake; one outstanding request at a time
	a_ack_holds: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		ACK_REQ_OUT && !ACK_DONE_IN && !clr_all |=> ACK_REQ_OUT)
		else $error("acknowledge request dropped early");
	a_ack_ends: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		ACK_REQ_OUT && ACK_DONE_IN |=> !ACK_REQ_OUT)
		else $error("acknowledge request outlived its completion");
	a_oversize_no_ack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!ACK_REQ_OUT && RX_MSG_VALID_IN && RX_LEN_IN > MAX_MSG_BYTES |=> !ACK_REQ_OUT)
		else $error("oversize message acknowledged");
	a_type_no_ack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!ACK_REQ_OUT && RX_MSG_VALID_IN && RX_FRAME_TYPE_IN > LAST_MSG_TYPE |=> !ACK_REQ_OUT)
		else $error("non-message frame acknowledged");
	a_disabled_no_ack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		!ACK_REQ_OUT && RX_MSG_VALID_IN && RX_FRAME_TYPE_IN <= LAST_MSG_TYPE
		&& !RX_DETECT_OUT[RX_FRAME_TYPE_IN] |=> !ACK_REQ_OUT)
		else $error("disabled message type acknowledged");

	// clears from reset signalling, one-more and idle enables
	a_full_reset_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		HARD_RESET_RX_IN && RX_DETECT_OUT[DET_FULL_RESET_BIT]
		|=> RX_DETECT_OUT == DET_RESET && RX_COUNT_CLEAR_OUT)
		else $error("received full reset did not clear enables");
	a_plug_reset_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		CABLE_RESET_RX_IN && RX_DETECT_OUT[DET_PLUG_RESET_BIT]
		|=> RX_DETECT_OUT == DET_RESET && RX_COUNT_CLEAR_OUT)
		else $error("received plug reset did not clear enables");
	a_abandon_ack: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		(HARD_RESET_SENT_IN || DISCONNECT_IN) && ACK_REQ_OUT && !ACK_DONE_IN
		&& !s_r.ack_one_more |=> !ACK_REQ_OUT)
		else $error("acknowledge kept across a link reset");
	a_clear_one_more: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		HARD_RESET_SENT_IN || DISCONNECT_IN |=> !s_r.one_more)
		else $error("pending one-more survived a clear");
	a_one_more_drop: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		RX_DETECT_OUT == DET_RESET |-> !s_r.one_more)
		else $error("one-more kept while nothing is enabled");
	a_one_more_count: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
		ACK_REQ_OUT && ACK_DONE_IN && s_r.ack_one_more |=> RX_COUNT_CLEAR_OUT)
		else $error("one-more acknowledge did not clear the count");

endmodule : pdr_regs

/* File: sim/pdr_ack_partner.sv */
`timescale 1ns/1ps
// behavioural transmitter that sends the acknowledge after a chosen number of cycles
module pdr_ack_partner
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// acknowledge handshake
	input wire logic req_in,
	input wire logic [3:0] delay_in,
	output logic done_out
);
	logic [3:0] cnt_r;
	// done is a single pulse, so one request never sees two completions
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in || done_out || !req_in)
		begin
			cnt_r <= 4'h0;
			done_out <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 4'h1;
			done_out <= (cnt_r == delay_in);
		end
endmodule : pdr_ack_partner

/* File: sim/pdr_regs_bench.sv */
`timescale 1ns/1ps
module pdr_regs_bench;
	import pdr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mv = 1'b0, isack = 1'b0, om = 1'b0;
	logic rvalid, err, req, cclr, done;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, hh, dv;
	logic [3:0] evt = 4'h0, dly = 4'h0;
	logic [2:0] ft = 3'h0;
	logic [8:0] len = 9'h000;
	pdr_hdr_t hdr;
	logic [DET_WIDTH-1:0] det;
	logic [7:0] expq[$];
	logic [7:0] ad[7] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2e, 8'h2f};
	logic [7:0] ex[7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0d, 8'h00};
	int n_errors = 0, n_compared = 0;
	int unsigned seed;
	pdr_regs pdr_regs_i (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.I2C_ERR_SET_OUT(err), .RX_MSG_VALID_IN(mv), .RX_FRAME_TYPE_IN(ft), .RX_LEN_IN(len),
		.RX_IS_ACK_IN(isack), .RX_ONE_MORE_IN(om), .HARD_RESET_SENT_IN(evt[0]),
		.DISCONNECT_IN(evt[1]), .HARD_RESET_RX_IN(evt[2]), .CABLE_RESET_RX_IN(evt[3]),
		.ACK_REQ_OUT(req), .ACK_DONE_IN(done), .ACK_HEADER_OUT(hdr), .RX_DETECT_OUT(det),
		.RX_COUNT_CLEAR_OUT(cclr));
	pdr_ack_partner pdr_ack_partner_i (.clk_in(clk), .rst_in(rst), .req_in(req),
		.delay_in(dly), .done_out(done));
	initial
		forever
			#2 clk = ~clk;
	task automatic conclude();
		// a read that never raised valid would otherwise pass unseen
		if (expq.size() != 0)
		begin
			n_errors++;
			$display("Error %0t %0d reads never answered", $time, expq.size());
		end
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input logic [7:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t byte %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk1(input logic got, exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1
	// inputs move one step after the edge so the design never races the bench
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic wreg(input logic [7:0] a, d, input logic e);
		addr = a;
		wd = d;
		wr = 1'b1;
		tick();
		wr = 1'b0;
		chk1(err, e);
		tick();
	endtask : wreg
	task automatic rreg(input logic [7:0] a, e);
		addr = a;
		rd = 1'b1;
		expq.push_back(e);
		tick();
		rd = 1'b0;
		tick();
	endtask : rreg
	// bounded wait for the acknowledge to finish; a hang ends the run
	task automatic msg(input logic [2:0] t, input logic [8:0] l, input logic a, e, c);
		ft = t;
		len = l;
		isack = a;
		mv = 1'b1;
		tick();
		mv = 1'b0;
		chk1(req, e);
		if (e)
			chk({3'h0, hdr}, hh);
		for (int i = 0; i < 40 && req === 1'b1; i++)
			tick();
		if (e)
			chk1(cclr, c);
		if (req !== 1'b0)
		begin
			n_errors++;
			conclude();
		end
		tick();
	endtask : msg
	// read data is matched to the oldest expectation as it appears
	always @(posedge clk)
		if (rvalid === 1'b1)
			chk(rdata, expq.size() > 0 ? expq.pop_front() : 8'hxx);
	initial
	begin
		seed = $urandom(37);
		repeat (20)
			@(posedge clk);
		#1;
		rst = 1'b0;
		tick();
		// fixed bytes survive random writes; 0x2b is unmapped and reads zero
		for (int p = 0; p < 2; p++)
		begin
			for (int i = 0; i < 7; i++)
				rreg(ad[i], ex[i]);
			for (int i = 0; i < 3; i++)
				wreg(ad[i], 8'($urandom), 1'b0);
		end
		wreg(8'h2a, 8'h02, 1'b1);
		wreg(8'h2a, 8'hfd, 1'b0);
		rreg(8'h2a, 8'h00);
		// header is written before any detection is enabled
		hh = 8'($urandom);
		wreg(8'h2e, hh, 1'b0);
		hh = hh & 8'h1f;
		rreg(8'h2e, hh);
		wreg(8'h2f, 8'hff, 1'b0);
		rreg(8'h2f, 8'h7f);
		// each type is acknowledged only under its own enable
		for (int t = 0; t < 5; t++)
		begin
			wreg(8'h2f, 8'(1 << t), 1'b0);
			dly = 4'($urandom % 8);
			msg(3'(t), 9'h01e, 1'b0, 1'b1, 1'b0);
			msg(3'(t), 9'($urandom % 31), 1'b1, 1'b0, 1'b0);
			msg(3'((t + 1) % 5), 9'h002, 1'b0, 1'b0, 1'b0);
		end
		wreg(8'h2f, 8'h1f, 1'b0);
		msg(3'h0, 9'h01f, 1'b0, 1'b0, 1'b0);
		// one-more clears the enables once its acknowledge is sent
		om = 1'b1;
		tick();
		om = 1'b0;
		msg(3'h0, 9'h004, 1'b0, 1'b1, 1'b1);
		rreg(8'h2f, 8'h00);
		wreg(8'h2f, 8'h01, 1'b0);
		om = 1'b1;
		tick();
		om = 1'b0;
		wreg(8'h2f, 8'h00, 1'b0);
		msg(3'h0, 9'h004, 1'b0, 1'b0, 1'b0);
		wreg(8'h2f, 8'h01, 1'b0);
		msg(3'h0, 9'h004, 1'b0, 1'b1, 1'b0);
		// received resets clear only under their own enable
		for (int i = 0; i < 4; i++)
			for (int b = 0; b < 2; b++)
			begin
				dv = ((i == 2) ^ (b == 1)) ? 8'h5f : 8'h3f;
				wreg(8'h2f, dv, 1'b0);
				evt = 4'(1 << i);
				tick();
				evt = 4'h0;
				chk1(cclr, i < 2 || b == 1);
				chk({1'b0, det}, (i < 2 || b == 1) ? 8'h00 : dv);
				tick();
			end
		conclude();
	end
endmodule : pdr_regs_bench
